// [design/status_regs.svh]
// Register selects, bit positions, reset values and sizes of the status block.
`ifndef STATUS_SERVICE_REGS_SVH
`define STATUS_SERVICE_REGS_SVH

// Command register selects.
`define SEL_STATUS_BYTE      3'h0
`define SEL_REQUEST_MASK     3'h1
`define SEL_LIVE_FAULT       3'h2
`define SEL_LATCHED_FAULT    3'h3
`define SEL_FAULT_MASK       3'h4

// Status summary byte bit positions.
`define BYTE_DONE_BIT        0
`define BYTE_ERR_BIT         2
`define BYTE_FAULT_BIT       3
`define BYTE_RESP_BIT        4
`define BYTE_EVENT_BIT       5
`define BYTE_REQ_BIT         6

// Request enable bits that may raise a request; bit 6 is excluded.
`define REQ_ENABLE_USED      8'hBF

// Live fault bits that exist: 0..4 and 8.
`define FAULT_USED_MASK      16'h011F
`define FAULT_OVERTEMP_BIT   0
`define FAULT_OPEN_LOAD_BIT  1
`define FAULT_SAFETY_BIT     2
`define FAULT_CUR_LIMIT_BIT  3
`define FAULT_TEMP_WIN_BIT   4
`define FAULT_SUPPLY_BIT     8

// Only the low byte of the latched faults feeds the status byte.
`define DES_SOURCE_W         8

// Reset values.
`define RST_BYTE             8'h00
`define RST_WORD             16'h0000

// Error queue depth and counter width.
`define ERRQ_DEPTH           32
`define ERRQ_CNT_W           6

`endif

// [design/status_pkg.sv]
// State types of the status and service request block.
package status_pkg;

`include "status_regs.svh"

    typedef struct packed {
        logic [15:0]             latched_q;
    } latch_state_type;

    typedef struct packed {
        logic [15:0]             live_q;
        logic [7:0]              req_mask_q;
        logic [15:0]             evt_mask_q;
        logic                    resp_avail_q;
        logic                    event_sum_q;
        logic                    done_q;
        logic                    finished_q;
        logic [`ERRQ_CNT_W-1:0]  err_count_q;
        logic                    ovf_q;
        logic [7:0]              byte_q;
        logic                    srq_q;
        logic                    resp_valid_q;
        logic [15:0]             resp_data_q;
        logic                    poll_valid_q;
        logic [7:0]              poll_data_q;
    } status_state_type;

endpackage

// [design/fault_event_latch.sv]
// Sticky latch of fault events with clear on read.
`timescale 1ns/1ps
`default_nettype none
`include "status_regs.svh"

module fault_event_latch #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    // Live conditions and read clear.
    input  wire logic [WIDTH-1:0] live_in,
    input  wire logic             clear_in,
    // Latched events.
    output logic      [WIDTH-1:0] latched_out
);

    status_pkg::latch_state_type s_q;
    status_pkg::latch_state_type s_d;

    always_comb begin
        s_d = s_q;
        if (clear_in) begin
            s_d.latched_q = '0;
        end
        // A condition present in the clearing cycle survives the clear.
        s_d.latched_q = s_d.latched_q | live_in[15:0];
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s_q.latched_q <= `RST_WORD;
        end else begin
            s_q <= s_d;
        end
    end

    assign latched_out = s_q.latched_q;

endmodule // fault_event_latch

`default_nettype wire

// [design/status_service_request.sv]
// Status summary byte, service request and device fault registers.
//
// Summary of operation
// - Status byte is read only by query or poll; all flags active high.
// - Response-available flag follows the output queue not-empty input.
// - Error-pending flag is high while the error queue holds entries.
// - Command-finished flag rises after completion and other flags updated.
// - Bit 3 is OR of low 8 latched faults AND fault mask.
// - Bits 0-5,7 ANDed with request mask, ORed, drive bit 6 and request.
// - Bit 6 itself never takes part in the request enable logic.
// - Bit 6 shows request in poll reply, summary in status query.
// - While a request is asserted bit 6 reads as one.
// - Live fault bits follow their faults and drop by themselves.
// - Live bits: 0 temp, 1 open load, 2 safety, 3 limit, 4 window, 8 supply.
// - Live fault register is read only and reading leaves it unchanged.
// - Each live fault bit sets its latched bit, which stays set.
// - Latched fault register is not writable; a read returns then clears.
// - Bit 5 is OR of standard events enabled by their mask.
// - Error queue holds 32 entries; overflow is reported as an error.
`timescale 1ns/1ps
`default_nettype none
`include "status_regs.svh"

module status_service_request #(
    parameter int ERRQ_DEPTH = `ERRQ_DEPTH
) (
    // Clock and reset.
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_IN,

    // Command port from the message parser.
    input  wire logic        CMD_VALID_IN,
    input  wire logic        CMD_WRITE_IN,
    input  wire logic [2:0]  CMD_SEL_IN,
    input  wire logic [15:0] CMD_WDATA_IN,
    input  wire logic        CMD_DONE_IN,

    // Serial poll request from the bus interface.
    input  wire logic        POLL_IN,

    // Queue status from the message layer.
    input  wire logic        OUTQ_NOT_EMPTY_IN,
    input  wire logic        ERR_PUSH_IN,
    input  wire logic        ERR_POP_IN,

    // Standard event register and its enable mask.
    input  wire logic [7:0]  STD_EVENT_IN,
    input  wire logic [7:0]  STD_EVENT_MASK_IN,

    // Live fault conditions from the hardware monitors.
    input  wire logic [15:0] FAULT_IN,

    // Command answers.
    output logic             RESP_VALID_OUT,
    output logic [15:0]      RESP_DATA_OUT,

    // Serial poll answers.
    output logic             POLL_VALID_OUT,
    output logic [7:0]       POLL_DATA_OUT,

    // Status and bus request.
    output logic [7:0]       STATUS_BYTE_OUT,
    output logic             SRQ_OUT,

    // Error queue state.
    output logic [`ERRQ_CNT_W-1:0] ERR_COUNT_OUT,
    output logic             ERR_OVERFLOW_OUT
);

    localparam logic [`ERRQ_CNT_W-1:0] ERRQ_FULL =
        `ERRQ_CNT_W'(ERRQ_DEPTH);

    status_pkg::status_state_type s_q;
    status_pkg::status_state_type s_d;

    logic [15:0] latched;
    logic        rd_cmd;
    logic        wr_cmd;
    logic        latch_clear;

    // Any bit set in both vectors.
    function automatic logic any_hit(
        input logic [15:0] a,
        input logic [15:0] b
    );
        any_hit = |(a & b);
    endfunction

    // Register read multiplexer.
    function automatic logic [15:0] read_mux(
        input logic [2:0]  sel,
        input logic [7:0]  status_byte,
        input logic [7:0]  req_mask,
        input logic [15:0] live,
        input logic [15:0] lat,
        input logic [15:0] evt_mask
    );
        case (sel)
            `SEL_STATUS_BYTE: begin
                read_mux = {8'h00, status_byte};
            end
            `SEL_REQUEST_MASK: begin
                read_mux = {8'h00, req_mask};
            end
            `SEL_LIVE_FAULT: begin
                read_mux = live;
            end
            `SEL_LATCHED_FAULT: begin
                read_mux = lat;
            end
            `SEL_FAULT_MASK: begin
                read_mux = evt_mask;
            end
            default: begin
                read_mux = `RST_WORD;
            end
        endcase
    endfunction

    assign rd_cmd      = CMD_VALID_IN & ~CMD_WRITE_IN;
    assign wr_cmd      = CMD_VALID_IN & CMD_WRITE_IN;
    // Clearing with the read keeps the returned word and the clear atomic.
    assign latch_clear = rd_cmd & (CMD_SEL_IN == `SEL_LATCHED_FAULT);

    fault_event_latch #(
        .WIDTH       (16)
    ) u_latch (
        .clock_in    (CLOCK_IN),
        .rst_in      (RST_IN),
        .live_in     (s_q.live_q),
        .clear_in    (latch_clear),
        .latched_out (latched)
    );

    always_comb begin
        logic [7:0] byte_c;
        logic       summary;
        byte_c  = `RST_BYTE;
        summary = 1'b0;
        s_d     = s_q;

        // Live faults follow the monitors; unused bits stay low.
        s_d.live_q = FAULT_IN & `FAULT_USED_MASK;

        s_d.resp_avail_q = OUTQ_NOT_EMPTY_IN;
        s_d.event_sum_q  = any_hit({8'h00, STD_EVENT_IN},
                                   {8'h00, STD_EVENT_MASK_IN});

        // Mask writes; the other registers ignore writes.
        if (wr_cmd) begin
            case (CMD_SEL_IN)
                `SEL_REQUEST_MASK: begin
                    s_d.req_mask_q = CMD_WDATA_IN[7:0];
                end
                `SEL_FAULT_MASK: begin
                    s_d.evt_mask_q = CMD_WDATA_IN;
                end
                default: begin
                    s_d.req_mask_q = s_q.req_mask_q;
                end
            endcase
        end

        // Error queue occupancy; a push into a full queue is an overflow.
        s_d.ovf_q = 1'b0;
        if (ERR_PUSH_IN && !ERR_POP_IN) begin
            if (s_q.err_count_q == ERRQ_FULL) begin
                s_d.ovf_q = 1'b1;
            end else begin
                s_d.err_count_q = s_q.err_count_q + `ERRQ_CNT_W'(1);
            end
        end else if (ERR_POP_IN && !ERR_PUSH_IN) begin
            if (s_q.err_count_q != '0) begin
                s_d.err_count_q = s_q.err_count_q - `ERRQ_CNT_W'(1);
            end
        end else if (ERR_PUSH_IN && ERR_POP_IN) begin
            if (s_q.err_count_q == '0) begin
                s_d.err_count_q = `ERRQ_CNT_W'(1);
            end
        end

        // Finish is delayed one stage so it never leads the other flags.
        s_d.done_q = CMD_DONE_IN;
        if (s_q.done_q) begin
            s_d.finished_q = 1'b1;
        end else if (CMD_VALID_IN) begin
            s_d.finished_q = 1'b0;
        end

        // Status byte from registered sources.
        byte_c[`BYTE_DONE_BIT] = s_q.finished_q;
        byte_c[`BYTE_ERR_BIT] = (s_q.err_count_q != '0);
        byte_c[`BYTE_FAULT_BIT] = any_hit(
            {8'h00, latched[`DES_SOURCE_W-1:0]},
            {8'h00, s_q.evt_mask_q[`DES_SOURCE_W-1:0]});
        byte_c[`BYTE_RESP_BIT] = s_q.resp_avail_q;
        byte_c[`BYTE_EVENT_BIT] = s_q.event_sum_q;

        // Bit 6 is masked off before the OR so it cannot feed back.
        summary = any_hit({8'h00, byte_c},
                          {8'h00, s_q.req_mask_q & `REQ_ENABLE_USED});
        byte_c[`BYTE_REQ_BIT] = summary;
        s_d.byte_q = byte_c;
        s_d.srq_q = summary;

        // Command answers one cycle after the read.
        s_d.resp_valid_q = rd_cmd;
        if (rd_cmd) begin
            s_d.resp_data_q = read_mux(CMD_SEL_IN, s_q.byte_q,
                                       s_q.req_mask_q, s_q.live_q,
                                       latched, s_q.evt_mask_q);
        end

        // Poll answer carries the request line state in bit 6.
        s_d.poll_valid_q = POLL_IN;
        if (POLL_IN) begin
            s_d.poll_data_q = s_q.byte_q;
            s_d.poll_data_q[`BYTE_REQ_BIT] = s_q.srq_q;
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s_q.live_q       <= `RST_WORD;
            s_q.req_mask_q   <= `RST_BYTE;
            s_q.evt_mask_q   <= `RST_WORD;
            s_q.resp_avail_q <= 1'b0;
            s_q.event_sum_q  <= 1'b0;
            s_q.done_q       <= 1'b0;
            s_q.finished_q   <= 1'b0;
            s_q.err_count_q  <= '0;
            s_q.ovf_q        <= 1'b0;
            s_q.byte_q       <= `RST_BYTE;
            s_q.srq_q        <= 1'b0;
            s_q.resp_valid_q <= 1'b0;
            s_q.resp_data_q  <= `RST_WORD;
            s_q.poll_valid_q <= 1'b0;
            s_q.poll_data_q  <= `RST_BYTE;
        end else begin
            s_q <= s_d;
        end
    end

    assign RESP_VALID_OUT   = s_q.resp_valid_q;
    assign RESP_DATA_OUT    = s_q.resp_data_q;
    assign POLL_VALID_OUT   = s_q.poll_valid_q;
    assign POLL_DATA_OUT    = s_q.poll_data_q;
    assign STATUS_BYTE_OUT  = s_q.byte_q;
    assign SRQ_OUT          = s_q.srq_q;
    assign ERR_COUNT_OUT    = s_q.err_count_q;
    assign ERR_OVERFLOW_OUT = s_q.ovf_q;

endmodule // status_service_request

`default_nettype wire

// [bench/status_service_request_asserts.sv]
// Checker of the status block port behaviour.
`timescale 1ns/1ps
`default_nettype none
`include "status_regs.svh"

module status_service_request_asserts #(
    parameter int ERRQ_DEPTH = 32
) (
    // Clock and reset.
    input wire logic        CLOCK_IN,
    input wire logic        RST_IN,
    // Stimulus.
    input wire logic        CMD_VALID_IN,
    input wire logic        CMD_WRITE_IN,
    input wire logic [2:0]  CMD_SEL_IN,
    input wire logic        CMD_DONE_IN,
    input wire logic        POLL_IN,
    input wire logic        OUTQ_NOT_EMPTY_IN,
    input wire logic        ERR_PUSH_IN,
    input wire logic        ERR_POP_IN,
    input wire logic [7:0]  STD_EVENT_IN,
    input wire logic [7:0]  STD_EVENT_MASK_IN,
    input wire logic [15:0] FAULT_IN,
    // Answers.
    input wire logic [15:0] RESP_DATA_OUT,
    input wire logic        POLL_VALID_OUT,
    input wire logic [7:0]  STATUS_BYTE_OUT,
    input wire logic        SRQ_OUT,
    input wire logic [`ERRQ_CNT_W-1:0] ERR_COUNT_OUT,
    input wire logic        ERR_OVERFLOW_OUT
);
    // Delayed terms are trusted only once three edges follow reset.
    logic [1:0] up_q;
    logic [1:0] up_d;
    always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) up_q <= 2'h0;
        else up_q <= up_d;
    end
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);

    property p_live_read;
        up_q == 2'h3 && CMD_VALID_IN && !CMD_WRITE_IN && CMD_SEL_IN == 3'h2
        |=> RESP_DATA_OUT == ($past(FAULT_IN, 2) & `FAULT_USED_MASK);
    endproperty
    a_live_read: assert property (p_live_read) else $error("live");
    property p_srq_bit;
        SRQ_OUT == STATUS_BYTE_OUT[6];
    endproperty
    a_srq_bit: assert property (p_srq_bit) else $error("srq bit");
    property p_resp_avail;
        up_q == 2'h3 |-> STATUS_BYTE_OUT[4] == $past(OUTQ_NOT_EMPTY_IN, 2);
    endproperty
    a_resp_avail: assert property (p_resp_avail) else $error("response");
    property p_err_pending;
        up_q == 2'h3 |-> STATUS_BYTE_OUT[2] == ($past(ERR_COUNT_OUT) != 0);
    endproperty
    a_err_pending: assert property (p_err_pending) else $error("errors");
    property p_finished;
        up_q == 2'h3 && $rose(STATUS_BYTE_OUT[0]) |-> $past(CMD_DONE_IN, 3);
    endproperty
    a_finished: assert property (p_finished) else $error("finished");
    property p_event_sum;
        up_q == 2'h3 |-> STATUS_BYTE_OUT[5] ==
            |($past(STD_EVENT_IN, 2) & $past(STD_EVENT_MASK_IN, 2));
    endproperty
    a_event_sum: assert property (p_event_sum) else $error("events");
    property p_overflow;
        ERR_PUSH_IN && !ERR_POP_IN && ERR_COUNT_OUT == `ERRQ_CNT_W'(ERRQ_DEPTH)
        |=> ERR_OVERFLOW_OUT && $stable(ERR_COUNT_OUT);
    endproperty
    a_overflow: assert property (p_overflow) else $error("ovf");
    property p_poll;
        POLL_IN |=> POLL_VALID_OUT;
    endproperty
    a_poll: assert property (p_poll) else $error("poll");
endmodule // status_service_request_asserts

bind status_service_request status_service_request_asserts #(
    .ERRQ_DEPTH(ERRQ_DEPTH)
) i_chk (
    .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .CMD_VALID_IN(CMD_VALID_IN),
    .CMD_WRITE_IN(CMD_WRITE_IN), .CMD_SEL_IN(CMD_SEL_IN),
    .CMD_DONE_IN(CMD_DONE_IN), .POLL_IN(POLL_IN),
    .OUTQ_NOT_EMPTY_IN(OUTQ_NOT_EMPTY_IN), .ERR_PUSH_IN(ERR_PUSH_IN),
    .ERR_POP_IN(ERR_POP_IN), .STD_EVENT_IN(STD_EVENT_IN),
    .STD_EVENT_MASK_IN(STD_EVENT_MASK_IN), .FAULT_IN(FAULT_IN),
    .RESP_DATA_OUT(RESP_DATA_OUT), .POLL_VALID_OUT(POLL_VALID_OUT),
    .STATUS_BYTE_OUT(STATUS_BYTE_OUT), .SRQ_OUT(SRQ_OUT),
    .ERR_COUNT_OUT(ERR_COUNT_OUT), .ERR_OVERFLOW_OUT(ERR_OVERFLOW_OUT)
);
`default_nettype wire

// [bench/bus_controller_model.sv]
// Behavioural bus controller issuing commands and serial polls.
`timescale 1ns/1ps
`default_nettype none

module bus_controller_model (
    // Clock.
    input  wire logic        clock_in,
    // Requests.
    output logic             cmd_valid_out,
    output logic             cmd_write_out,
    output logic [2:0]       cmd_sel_out,
    output logic [15:0]      cmd_wdata_out,
    output logic             poll_out,
    // Answers.
    input  wire logic        resp_valid_in,
    input  wire logic [15:0] resp_data_in,
    input  wire logic        poll_valid_in,
    input  wire logic [7:0]  poll_data_in
);
    logic        answered;
    logic [15:0] last_q;

    initial begin
        cmd_valid_out = 1'b0;
        cmd_write_out = 1'b0;
        cmd_sel_out = 3'h0;
        cmd_wdata_out = 16'h0000;
        poll_out = 1'b0;
    end

    // One request; the answer stands for one cycle after the taking edge.
    task automatic xfer(input logic wr, input logic [2:0] sel,
                        input logic [15:0] d, input logic pl);
        @(negedge clock_in);
        cmd_valid_out = !pl;
        cmd_write_out = wr;
        cmd_sel_out = sel;
        cmd_wdata_out = d;
        poll_out = pl;
        @(negedge clock_in);
        cmd_valid_out = 1'b0;
        poll_out = 1'b0;
        // Released data is inverted so a stale value cannot pass.
        cmd_wdata_out = ~d;
        answered = pl ? poll_valid_in : (wr | resp_valid_in);
        last_q = pl ? {8'h00, poll_data_in} : resp_data_in;
    endtask

    // Bit six set in any status reply means service is wanted.
    function automatic logic wants_service();
        return last_q[6];
    endfunction
endmodule // bus_controller_model
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench of the status and service request block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        clk, rst, done, outq, push, pop, cv, cw, pl, rv, pv, srq, ovf;
    logic [2:0]  sel;
    logic [15:0] wd, rdat, fault;
    logic [7:0]  sev, smask, pdat, sbyte, e;
    logic [5:0]  cnt_o;
    logic [31:0] r;
    int          failures, num_checks, rqm, evm, lat, cnt, command_finished_flag;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    status_service_request #(.ERRQ_DEPTH(4)) i_dut (
        .CLOCK_IN(clk), .RST_IN(rst), .CMD_VALID_IN(cv), .CMD_WRITE_IN(cw),
        .CMD_SEL_IN(sel), .CMD_WDATA_IN(wd), .CMD_DONE_IN(done),
        .POLL_IN(pl), .OUTQ_NOT_EMPTY_IN(outq), .ERR_PUSH_IN(push),
        .ERR_POP_IN(pop), .STD_EVENT_IN(sev), .STD_EVENT_MASK_IN(smask),
        .FAULT_IN(fault), .RESP_VALID_OUT(rv), .RESP_DATA_OUT(rdat),
        .POLL_VALID_OUT(pv), .POLL_DATA_OUT(pdat), .STATUS_BYTE_OUT(sbyte),
        .SRQ_OUT(srq), .ERR_COUNT_OUT(cnt_o), .ERR_OVERFLOW_OUT(ovf));
    bus_controller_model i_ctl (
        .clock_in(clk), .cmd_valid_out(cv), .cmd_write_out(cw),
        .cmd_sel_out(sel), .cmd_wdata_out(wd), .poll_out(pl),
        .resp_valid_in(rv), .resp_data_in(rdat), .poll_valid_in(pv),
        .poll_data_in(pdat));

    task automatic chk(input string w, input logic [15:0] x, input logic [15:0] g);
        num_checks++;
        if (g !== x) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", w, x, g);
        end
    endtask
    function automatic logic [7:0] byte_exp();
        logic [7:0] b;
        b = {2'b00, |(sev & smask), outq, |(lat[7:0] & evm[7:0]), cnt != 0,
             1'b0, command_finished_flag[0]};
        b[6] = |(b & rqm[7:0] & 8'hBF);
        return b;
    endfunction
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rd(input logic [2:0] s, input logic [15:0] x);
        i_ctl.xfer(1'b0, s, 16'h0000, 1'b0);
        chk("answer", 16'h0001, {15'h0000, i_ctl.answered});
        chk("read", x, i_ctl.last_q);
        command_finished_flag = 0;
    endtask
    task automatic wr(input logic [2:0] s, input logic [15:0] d);
        i_ctl.xfer(1'b1, s, d, 1'b0);
        command_finished_flag = 0;
        if (s == 3'h1) rqm = d[7:0];
        if (s == 3'h4) evm = d;
    endtask
    task automatic status(input string n);
        e = byte_exp();
        chk("status", {8'h00, e}, {8'h00, sbyte});
        chk("srq", {15'h0000, e[6]}, {15'h0000, srq});
        $display("test %s ended", n);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        {failures, num_checks, rqm, evm, lat, cnt, command_finished_flag} = '0;
        {done, outq, push, pop, sev, smask, fault} = '0;
        rst = 1'b1;
        r = $urandom(32'h385F05A6);
        idle(8);
        rst = 1'b0;
        rd(3'h1, 0);
        rd(3'h4, 0);
        for (int s = 5; s < 8; s++) rd(s[2:0], 0);
        r = $urandom;
        wr(3'h4, r[15:0]);
        rd(3'h4, r[15:0]);
        for (int s = 0; s < 4; s++) if (s != 1) wr(s[2:0], 16'hFFFF);
        rd(3'h2, 0);
        rd(3'h3, 0);
        rd(3'h0, 0);
        fault = r[31:16];
        idle(3);
        rd(3'h2, fault & 16'h011F);
        rd(3'h2, fault & 16'h011F);
        lat = fault & 16'h011F;
        fault = 16'h0000;
        idle(3);
        rd(3'h2, 0);
        rd(3'h3, lat[15:0]);
        lat = 0;
        rd(3'h3, 0);
        wr(3'h4, 16'h0001);
        wr(3'h1, 16'h0008);
        fault = 16'h0001;
        idle(2);
        fault = 16'h0000;
        lat = 1;
        idle(4);
        status("fault request");
        i_ctl.xfer(1'b0, 3'h0, 16'h0000, 1'b1);
        chk("poll answer", 16'h0001, {15'h0000, i_ctl.answered});
        chk("poll", {8'h00, byte_exp()}, i_ctl.last_q);
        chk("service", 16'h0001, {15'h0000, i_ctl.wants_service()});
        rd(3'h3, 16'h0001);
        lat = 0;
        idle(4);
        status("release");
        wr(3'h1, 16'h0040);
        outq = 1'b1;
        idle(3);
        status("bit six excluded");
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            {outq, smask, sev} = r[16:0];
            wr(3'h1, {8'h00, r[31:24]});
            idle(3);
            status("random summary");
        end
        done = 1'b1;
        idle(1);
        done = 1'b0;
        command_finished_flag = 1;
        idle(3);
        status("finished");
        rd(3'h0, {8'h00, byte_exp()});
        idle(3);
        status("finished cleared");
        push = 1'b1;
        repeat (5) begin
            idle(1);
            cnt += (cnt < 4);
        end
        chk("overflow", 16'h0001, {15'h0000, ovf});
        push = 1'b0;
        idle(2);
        chk("count", 16'(cnt), {10'h000, cnt_o});
        status("error full");
        pop = 1'b1;
        idle(5);
        pop = 1'b0;
        cnt = 0;
        idle(2);
        chk("count", 16'h0000, {10'h000, cnt_o});
        status("error empty");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
